/* File: inc/nwc_pkg.sv */
// constants, types and decode helpers for the nested walk entry checker
// assumes one clock domain; entries arrive as 64-bit little-endian words
//
// Notes on behaviour
// - permission 010b or 110b is misconfiguration
// - 100b misconfigured unless execute-only supported
// - execute-only support visible as capability output
// - present entry with reserved bit is misconfigured
// - reserved memory type on final entry misconfigures
// - violation only when no misconfiguration
// - not-present entry on the walk violates
// - data read needs read bit everywhere
// - guest table reads count as data reads
// - data write needs write bit everywhere
// - accessed/dirty updates count as data writes
// - fetch needs execute bit everywhere
// - pointer load in three-level mode is walked
// - all-zero permissions means entry not present
// - size bit selects large page or table
// - per-entry checks first, permissions at end
package nwc_pkg;

	localparam int PA_W = 52;
	localparam int GPA_W = 48;
	localparam int PHYS_ADDR_WIDTH = 40;
	localparam logic XO_SUPPORTED = 1'b1;

	localparam int RD_BIT = 0;
	localparam int WR_BIT = 1;
	localparam int EX_BIT = 2;
	localparam int SIZE_BIT = 7;
	localparam int MT_LO = 3;
	localparam int MT_HI = 5;

	localparam logic [1:0] LVL_TOP = 2'h3;
	localparam logic [1:0] LVL_LEAF = 2'h0;

	localparam logic [2:0] PERM_WO = 3'h2;
	localparam logic [2:0] PERM_WX = 3'h6;
	localparam logic [2:0] PERM_XO = 3'h4;
	localparam logic [2:0] PERM_NONE = 3'h0;
	localparam logic [2:0] PERM_RST = 3'h7;

	// address bits from the physical width up to bit 51 are reserved
	localparam logic [63:0] HI_RSVD =
		((64'h0000_0000_0000_0001 << PA_W) - 64'h0000_0000_0000_0001) &
		~((64'h0000_0000_0000_0001 << PHYS_ADDR_WIDTH) - 64'h0000_0000_0000_0001);
	localparam logic [63:0] RSVD_TOP = 64'h0000_0000_0000_00f8;
	localparam logic [63:0] RSVD_TBL = 64'h0000_0000_0000_0078;
	localparam logic [63:0] RSVD_1G = 64'h0000_0000_3fff_f000;
	localparam logic [63:0] RSVD_2M = 64'h0000_0000_001f_f000;

	typedef enum logic [2:0] {
		AC_READ, AC_WRITE, AC_FETCH, AC_GPT_READ, AC_GPT_AD, AC_BASE_LOAD
	} nwc_acc_class_t;

	typedef enum logic [1:0] {AK_NONE, AK_READ, AK_WRITE, AK_FETCH} nwc_acc_kind_t;

	typedef enum logic [1:0] {RS_NONE, RS_PASS, RS_MISCONF, RS_VIOL} nwc_res_t;

	typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_EVAL, ST_PERM, ST_DONE} nwc_state_t;

	function automatic logic [63:0] nwc_rsvd_mask(input logic [1:0] lvl, input logic leaf);
		logic [63:0] m;
		m = HI_RSVD;
		if (lvl == LVL_TOP) begin
			m = m | RSVD_TOP;
		end else if (lvl == 2'h2) begin
			m = m | (leaf ? RSVD_1G : RSVD_TBL);
		end else if (lvl == 2'h1) begin
			m = m | (leaf ? RSVD_2M : RSVD_TBL);
		end
		return m;
	endfunction : nwc_rsvd_mask

	function automatic logic nwc_mt_rsvd(input logic [2:0] mt);
		return (mt == 3'h2) || (mt == 3'h3) || (mt == 3'h7);
	endfunction : nwc_mt_rsvd

endpackage : nwc_pkg

/* File: inc/nwc_ent_if.sv */
// signals between the walk controller and its entry and permission checkers
// assumes all three sit on the same clock; contents are combinational
`timescale 1ns/1ns
`default_nettype none
interface nwc_ent_if;
	import nwc_pkg::*;
	logic [63:0] ent;
	logic [1:0] lvl;
	logic [GPA_W-1:0] gpa;
	logic present;
	logic misconf;
	logic leaf;
	logic [PA_W-1:12] next_base;
	logic [PA_W-1:0] leaf_addr;
	logic [2:0] perm_acc;
	nwc_acc_class_t cls;
	logic denied;
	nwc_acc_kind_t deny_kind;

	modport walk (output ent, lvl, gpa, perm_acc, cls,
		input present, misconf, leaf, next_base, leaf_addr, denied, deny_kind);
	modport chk (input ent, lvl, gpa,
		output present, misconf, leaf, next_base, leaf_addr);
	modport perm (input perm_acc, cls, output denied, deny_kind);
endinterface : nwc_ent_if
`default_nettype wire

/* File: src/nwc_entry_check.sv */
// per-entry presence, configuration and address decode
// assumes the entry and its level are stable for the cycle it is judged
`timescale 1ns/1ns
`default_nettype none
module nwc_entry_check
	import nwc_pkg::*;
(
	nwc_ent_if.chk e // entry under test and its verdict
);
	logic [2:0] p;
	logic [63:0] m;

	assign p = e.ent[EX_BIT:RD_BIT];
	assign e.present = (p != PERM_NONE);
	// bit 7 of the top level is reserved, so it never makes a leaf
	assign e.leaf = (e.lvl == LVL_LEAF) ||
		((e.lvl != LVL_TOP) && e.ent[SIZE_BIT]);
	assign m = nwc_rsvd_mask(e.lvl, e.leaf);

	always_comb begin
		e.misconf = 1'b0;
		if (e.present) begin
			if (p == PERM_WO || p == PERM_WX) begin
				e.misconf = 1'b1;
			end
			if (p == PERM_XO && !XO_SUPPORTED) begin
				e.misconf = 1'b1;
			end
			if ((e.ent & m) != 64'h0000_0000_0000_0000) begin
				e.misconf = 1'b1;
			end
			if (e.leaf && nwc_mt_rsvd(e.ent[MT_HI:MT_LO])) begin
				e.misconf = 1'b1;
			end
		end
	end

	assign e.next_base = e.ent[PA_W-1:12];

	always_comb begin
		unique case (e.lvl)
			2'h2: e.leaf_addr = {e.ent[PA_W-1:30], e.gpa[29:0]};
			2'h1: e.leaf_addr = {e.ent[PA_W-1:21], e.gpa[20:0]};
			default: e.leaf_addr = {e.ent[PA_W-1:12], e.gpa[11:0]};
		endcase
	end
endmodule : nwc_entry_check
`default_nettype wire

/* File: src/nwc_perm_eval.sv */
// final permission test against the permissions gathered along the walk
// assumes the gathered set is the AND of every entry used
`timescale 1ns/1ns
`default_nettype none
module nwc_perm_eval
	import nwc_pkg::*;
(
	nwc_ent_if.perm e // gathered permissions and access class
);
	always_comb begin
		e.denied = 1'b0;
		e.deny_kind = AK_NONE;
		unique case (e.cls)
			AC_WRITE, AC_GPT_AD: begin
				e.denied = !e.perm_acc[WR_BIT];
				e.deny_kind = AK_WRITE;
			end
			AC_FETCH: begin
				e.denied = !e.perm_acc[EX_BIT];
				e.deny_kind = AK_FETCH;
			end
			default: begin
				e.denied = !e.perm_acc[RD_BIT];
				e.deny_kind = AK_READ;
			end
		endcase
		if (!e.denied) begin
			e.deny_kind = AK_NONE;
		end
	end
endmodule : nwc_perm_eval
`default_nettype wire

/* File: src/nwc_walk_checker.sv */
// nested table walk controller with entry and permission checking
// assumes the caller answers each entry fetch on the same clock
`timescale 1ns/1ns
`default_nettype none
module nwc_walk_checker
	import nwc_pkg::*;
(
	input wire logic ref_clk, // 25 MHz clock
	input wire logic rst, // synchronous reset, high
	input wire logic xl_start, // start a translation
	output logic xl_ready, // idle, start accepted
	input wire logic [GPA_W-1:0] xl_gpa, // guest-physical address
	input wire logic [2:0] xl_class, // access class code
	input wire logic [PA_W-1:12] ntp_base, // top table base
	input wire logic paging_on_flag, // guest paging enabled
	input wire logic ext_paging_flag, // guest extended paging
	input wire logic long_mode_active_flag, // guest long mode
	output logic nested_xlate_capability, // execute-only support
	output logic walk_req_valid, // entry fetch request
	output logic [PA_W-1:0] walk_req_addr, // entry address
	input wire logic walk_rsp_valid, // entry returned
	input wire logic [63:0] walk_rsp_entry, // entry data
	output logic res_valid, // result pulse
	output logic [1:0] res_status, // pass/misconf/viol
	output logic [PA_W-1:0] res_addr, // final address on pass
	output logic [1:0] res_fail_kind, // access kind denied
	output logic [1:0] res_level // level walk ended at
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		nwc_state_t st;
		logic [GPA_W-1:0] gpa;
		nwc_acc_class_t cls;
		logic [1:0] lvl;
		logic [PA_W-1:12] base;
		logic [2:0] perm;
		logic [63:0] ent;
		nwc_res_t res;
		logic [PA_W-1:0] addr;
		nwc_acc_kind_t fk;
	} nwc_walk_t;

	nwc_walk_t s_r;
	nwc_walk_t s_nxt;
	nwc_ent_if e ();
	logic three_level_mode;

	// ---------------------------------------------------------------
	// checkers
	// ---------------------------------------------------------------
	nwc_entry_check u_entry (
		.e(e.chk)
	);

	nwc_perm_eval u_perm (
		.e(e.perm)
	);

	assign e.ent = s_r.ent;
	assign e.lvl = s_r.lvl;
	assign e.gpa = s_r.gpa;
	assign e.perm_acc = s_r.perm;
	assign e.cls = s_r.cls;

	// only the three-level extended mode fetches pointer entries on load
	assign three_level_mode = paging_on_flag && ext_paging_flag &&
		!long_mode_active_flag;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		unique case (s_r.st)
			ST_IDLE: begin
				if (xl_start) begin
					s_nxt.gpa = xl_gpa;
					s_nxt.cls = nwc_acc_class_t'(xl_class);
					s_nxt.lvl = LVL_TOP;
					s_nxt.base = ntp_base;
					s_nxt.perm = PERM_RST;
					s_nxt.res = RS_NONE;
					s_nxt.fk = AK_NONE;
					s_nxt.addr = '0;
					s_nxt.st = ST_REQ;
					if (nwc_acc_class_t'(xl_class) == AC_BASE_LOAD &&
						!three_level_mode) begin
						// plain base load touches no memory
						s_nxt.res = RS_PASS;
						s_nxt.addr = {{(PA_W-GPA_W){1'b0}}, xl_gpa};
						s_nxt.st = ST_DONE;
					end
				end
			end
			ST_REQ: begin
				if (walk_rsp_valid) begin
					s_nxt.ent = walk_rsp_entry;
					s_nxt.st = ST_EVAL;
				end
			end
			ST_EVAL: begin
				if (!e.present) begin
					s_nxt.res = RS_VIOL;
					s_nxt.fk = AK_NONE;
					s_nxt.st = ST_DONE;
				end else if (e.misconf) begin
					s_nxt.res = RS_MISCONF;
					s_nxt.st = ST_DONE;
				end else begin
					s_nxt.perm = s_r.perm & s_r.ent[EX_BIT:RD_BIT];
					if (e.leaf) begin
						s_nxt.addr = e.leaf_addr;
						s_nxt.st = ST_PERM;
					end else begin
						s_nxt.base = e.next_base;
						s_nxt.lvl = s_r.lvl - 2'h1;
						s_nxt.st = ST_REQ;
					end
				end
			end
			ST_PERM: begin
				if (e.denied) begin
					s_nxt.res = RS_VIOL;
					s_nxt.fk = e.deny_kind;
				end else begin
					s_nxt.res = RS_PASS;
				end
				s_nxt.st = ST_DONE;
			end
			ST_DONE: begin
				s_nxt.st = ST_IDLE;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		if (rst) begin
			s_nxt = '0;
			s_nxt.st = ST_IDLE;
			s_nxt.cls = AC_READ;
			s_nxt.res = RS_NONE;
			s_nxt.fk = AK_NONE;
			s_nxt.perm = PERM_RST;
		end
	end

	always_ff @(posedge ref_clk) begin
		s_r <= s_nxt;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	function automatic logic [8:0] nwc_index(input logic [GPA_W-1:0] a,
		input logic [1:0] lvl);
		logic [8:0] ix;
		unique case (lvl)
			2'h3: ix = a[47:39];
			2'h2: ix = a[38:30];
			2'h1: ix = a[29:21];
			default: ix = a[20:12];
		endcase
		return ix;
	endfunction : nwc_index

	assign xl_ready = (s_r.st == ST_IDLE);
	assign nested_xlate_capability = XO_SUPPORTED;
	assign walk_req_valid = (s_r.st == ST_REQ);
	assign walk_req_addr = {s_r.base, nwc_index(s_r.gpa, s_r.lvl), 3'h0};

	// status, address, kind and level hold from the done cycle until the next start; res_valid pulses for the done cycle only
	assign res_valid = (s_r.st == ST_DONE);
	assign res_status = s_r.res;
	assign res_addr = s_r.addr;
	assign res_fail_kind = s_r.fk;
	assign res_level = s_r.lvl;

endmodule : nwc_walk_checker
`default_nettype wire

/* File: bench/nwc_tbl_mem.sv */
// table model: answers entry fetches from four slots, top level first
// assumes one fetch at a time and a restart pulse with every start
`timescale 1ns/1ns
`default_nettype none
module nwc_tbl_mem (
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic restart, // new walk
	input wire logic [2:0] slow, // wait cycles
	input wire logic [3:0][63:0] tbl, // entries
	input wire logic walk_req_valid, // fetch
	output logic walk_rsp_valid, // strobe
	output logic [63:0] walk_rsp_entry // entry
);
	logic [1:0] idx;
	logic [2:0] wait_c;
	logic [63:0] last;
	// released bus shows the inverse, so a stale entry never looks valid
	assign walk_rsp_entry = walk_rsp_valid ? tbl[idx] : ~last;
	always_ff @(posedge ref_clk) begin
		if (rst || restart) begin
			idx <= 2'h0;
			wait_c <= 3'h0;
			last <= 64'h0000_0000_0000_0000;
			walk_rsp_valid <= 1'b0;
		end else if (walk_rsp_valid) begin
			walk_rsp_valid <= 1'b0;
			idx <= idx + 2'h1;
			last <= tbl[idx];
		end else if (walk_req_valid && wait_c == slow) begin
			walk_rsp_valid <= 1'b1;
			wait_c <= 3'h0;
		end else if (walk_req_valid) begin
			wait_c <= wait_c + 3'h1;
		end
	end
endmodule : nwc_tbl_mem
`default_nettype wire

/* File: bench/nwc_rule_checker.sv */
// assertions on the walk checker top ports
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module nwc_rule_checker
	import nwc_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic rst, // reset
	input wire logic xl_start, // start
	input wire logic xl_ready, // idle
	input wire logic nested_xlate_capability, // cap
	input wire logic walk_req_valid, // fetch
	input wire logic walk_rsp_valid, // strobe
	input wire logic [63:0] walk_rsp_entry, // entry
	input wire logic res_valid, // result
	input wire logic [1:0] res_status, // status
	input wire logic [1:0] res_fail_kind // kind
);
	logic [1:0] lvl_r; // level of next entry
	wire logic [2:0] p = walk_rsp_entry[2:0];
	wire logic hi = |(walk_rsp_entry & HI_RSVD);
	wire logic [2:0] mt = walk_rsp_entry[5:3];
	always_ff @(posedge ref_clk) begin
		if (rst || (xl_start && xl_ready)) begin
			lvl_r <= 2'h3;
		end else if (walk_req_valid && walk_rsp_valid) begin
			lvl_r <= lvl_r - 2'h1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_take;
		walk_req_valid && walk_rsp_valid;
	endsequence
	sequence s_misc;
		##2 (res_valid && res_status == RS_MISCONF);
	endsequence
	a_cap_shown: assert property (nested_xlate_capability == XO_SUPPORTED)
		else $error("cap");
	a_start_busy: assert property (xl_start && xl_ready |=> !xl_ready)
		else $error("start");
	a_absent_viol: assert property (s_take ##0 (p == 3'h0) |-> ##2
		(res_valid && res_status == RS_VIOL && res_fail_kind == 2'h0)) else $error("absent");
	a_perm_misconf: assert property (s_take ##0 (p == PERM_WO || p == PERM_WX) |-> s_misc)
		else $error("perm");
	a_addr_misconf: assert property (s_take ##0 (p != 3'h0 && hi) |-> s_misc)
		else $error("addr");
	a_type_misconf: assert property (s_take ##0 (lvl_r == 2'h0 && p == 3'h7 &&
		mt inside {3'h2, 3'h3, 3'h7}) |-> s_misc) else $error("type");
	a_leaf_late: assert property (s_take ##0 (lvl_r == 2'h0 && p == 3'h7 && !hi &&
		mt == 3'h6) |-> ##3 (res_valid && res_status != RS_MISCONF)) else $error("leaf");
	a_one_pulse: assert property (res_valid |=> !res_valid)
		else $error("pulse");
endmodule : nwc_rule_checker
bind nwc_walk_checker nwc_rule_checker u_rules (
	.ref_clk(ref_clk),
	.rst(rst),
	.xl_start(xl_start),
	.xl_ready(xl_ready),
	.nested_xlate_capability(nested_xlate_capability),
	.walk_req_valid(walk_req_valid),
	.walk_rsp_valid(walk_rsp_valid),
	.walk_rsp_entry(walk_rsp_entry),
	.res_valid(res_valid),
	.res_status(res_status),
	.res_fail_kind(res_fail_kind)
);
`default_nettype wire

/* File: bench/nwc_walk_checker_test.sv */
// self-checking bench for the nested walk entry checker
// assumes the table model answers fetches; 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
module nwc_walk_checker_test;
	import nwc_pkg::*;
	localparam logic [63:0] PT = 64'h0000_0000_0012_3007; // table, all rights
	localparam logic [63:0] LF = 64'h0000_0000_0abc_d037; // 4K leaf
	localparam logic [63:0] LG = 64'h0000_0000_0a20_00b7; // 2M leaf
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic xl_start = 1'b0;
	logic [GPA_W-1:0] xl_gpa = 48'h0000_0040_3abc;
	logic [2:0] xl_class = 3'h0;
	logic [PA_W-1:12] ntp_base = 40'h00_0000_0100;
	logic paging_on_flag = 1'b0;
	logic ext_paging_flag = 1'b0;
	logic long_mode_active_flag = 1'b1;
	logic [2:0] slow = 3'h0;
	logic [3:0][63:0] tbl = {LF, PT, PT, PT};
	logic xl_ready, nested_xlate_capability, walk_req_valid, walk_rsp_valid, res_valid;
	logic [PA_W-1:0] walk_req_addr, res_addr;
	logic [63:0] walk_rsp_entry;
	logic [1:0] res_status, res_fail_kind, res_level;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	always #20 ref_clk = ~ref_clk;
	nwc_walk_checker DUT (
		.ref_clk(ref_clk),
		.rst(rst),
		.xl_start(xl_start),
		.xl_ready(xl_ready),
		.xl_gpa(xl_gpa),
		.xl_class(xl_class),
		.ntp_base(ntp_base),
		.paging_on_flag(paging_on_flag),
		.ext_paging_flag(ext_paging_flag),
		.long_mode_active_flag(long_mode_active_flag),
		.nested_xlate_capability(nested_xlate_capability),
		.walk_req_valid(walk_req_valid),
		.walk_req_addr(walk_req_addr),
		.walk_rsp_valid(walk_rsp_valid),
		.walk_rsp_entry(walk_rsp_entry),
		.res_valid(res_valid),
		.res_status(res_status),
		.res_addr(res_addr),
		.res_fail_kind(res_fail_kind),
		.res_level(res_level)
	);
	nwc_tbl_mem u_mem (
		.ref_clk(ref_clk),
		.rst(rst),
		.restart(xl_start && xl_ready),
		.slow(slow),
		.tbl(tbl),
		.walk_req_valid(walk_req_valid),
		.walk_rsp_valid(walk_rsp_valid),
		.walk_rsp_entry(walk_rsp_entry)
	);
	task automatic chk(input string nm, input logic [51:0] x, input logic [51:0] g);
		checks_done++;
		if (g !== x) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic xl(input logic [2:0] c, input logic [63:0] a, b, d, e,
		input logic [1:0] st, fk, lv);
		int n;
		n = 0;
		tbl = {e, d, b, a};
		xl_class = c;
		while (xl_ready !== 1'b1) begin
			@(posedge ref_clk);
			#1;
		end
		xl_start = 1'b1;
		@(posedge ref_clk);
		#1;
		xl_start = 1'b0;
		// first fetch goes to the top table slot picked by the top index
		if (res_valid !== 1'b1) begin
			chk("req_addr", {ntp_base, xl_gpa[47:39], 3'h0}, walk_req_addr);
		end
		while (res_valid !== 1'b1 && n < 60) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		// a walk that never ends must not pass on a stale status
		chk("res_valid", 52'h1, {51'h0, res_valid});
		chk("status", {50'h0, st}, {50'h0, res_status});
		chk("kind", {50'h0, fk}, {50'h0, res_fail_kind});
		chk("level", {50'h0, lv}, {50'h0, res_level});
	endtask : xl
	// --------
	// scenarios
	// --------
	task automatic t_pass();
		for (int c = 0; c < 5; c++) begin
			xl(c[2:0], PT, PT, PT, LF, RS_PASS, 2'h0, 2'h0);
			chk("addr", {LF[51:12], xl_gpa[11:0]}, res_addr);
		end
	endtask : t_pass
	task automatic t_viol();
		logic [2:0] pm [5] = '{3'h4, 3'h5, 3'h3, 3'h4, 3'h5};
		for (int c = 0; c < 5; c++) begin
			xl(c[2:0], PT, {PT[63:3], pm[c]}, PT, LF, RS_VIOL, pm[c] == 3'h3 ? 2'h3 : pm[c][1:0] + 2'h1, 2'h0);
		end
		xl(3'h2, PT, {PT[63:3], PERM_XO}, PT, LF, RS_PASS, 2'h0, 2'h0);
	endtask : t_viol
	task automatic t_misconf();
		logic [2:0] mt [3] = '{3'h2, 3'h3, 3'h7};
		xl(3'h0, {PT[63:3], PERM_WO}, PT, PT, LF, RS_MISCONF, 2'h0, 2'h3);
		xl(3'h0, PT, PT, {PT[63:3], PERM_WX}, LF, RS_MISCONF, 2'h0, 2'h1);
		xl(3'h1, PT, PT | 64'h0000_2000_0000_0000, PT, LF, RS_MISCONF, 2'h0, 2'h2);
		for (int i = 0; i < 3; i++) begin
			xl(3'h0, PT, PT, PT, {LF[63:6], mt[i], 3'h7}, RS_MISCONF, 2'h0, 2'h0);
		end
		xl(3'h1, PT, 64'hfff0_ffff_ffff_fff8, PT, LF, RS_VIOL, 2'h0, 2'h2);
	endtask : t_misconf
	task automatic t_large();
		slow = 3'h3;
		xl(3'h2, PT, PT, LG, PT, RS_PASS, 2'h0, 2'h1);
		chk("addr", {LG[51:21], xl_gpa[20:0]}, res_addr);
		slow = 3'h0;
		xl(3'h2, PT, PT, LG & ~64'h0000_0000_0000_0080, LF, RS_MISCONF, 2'h0, 2'h1);
		chk("cap", 52'h1, {51'h0, nested_xlate_capability});
	endtask : t_large
	task automatic t_base();
		xl(3'h5, 64'h0000_0000_0000_0000, PT, PT, LF, RS_PASS, 2'h0, 2'h3);
		chk("addr", {4'h0, xl_gpa}, res_addr);
		paging_on_flag = 1'b1;
		ext_paging_flag = 1'b1;
		long_mode_active_flag = 1'b0;
		xl(3'h5, 64'h0000_0000_0000_0000, PT, PT, LF, RS_VIOL, 2'h0, 2'h3);
	endtask : t_base
	task automatic t_reset();
		while (xl_ready !== 1'b1) begin
			@(posedge ref_clk);
			#1;
		end
		xl_class = 3'h0;
		xl_start = 1'b1;
		@(posedge ref_clk);
		#1;
		xl_start = 1'b0;
		// reset lands while the walk waits for its first entry
		rst = 1'b1;
		@(posedge ref_clk);
		#1;
		chk("rst_ready", 52'h1, {51'h0, xl_ready});
		chk("rst_req", 52'h0, {51'h0, walk_req_valid});
		chk("rst_valid", 52'h0, {51'h0, res_valid});
		chk("rst_status", 52'h0, {50'h0, res_status});
		chk("rst_addr", 52'h0, res_addr);
		rst = 1'b0;
		xl(3'h0, PT, PT, PT, LF, RS_PASS, 2'h0, 2'h0);
		chk("addr", {LF[51:12], xl_gpa[11:0]}, res_addr);
	endtask : t_reset
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		t_pass();
		t_viol();
		t_misconf();
		t_large();
		t_base();
		t_reset();
		test_done();
	end
endmodule : nwc_walk_checker_test
`default_nettype wire
